// ---- logic/fan_sense_pkg.sv ----
// Types shared by the fan sense configuration block and its helpers.
// Assumes the constants header is included wherever numbers are needed.
package fan_sense_pkg;

   // Role of the shared multi-function pin.
   typedef enum logic [1:0] {
      ROLE_FAN_SPEED = 2'b00,
      ROLE_OVERTEMP  = 2'b01,
      ROLE_BUS_ALERT = 2'b10,
      ROLE_GPIO      = 2'b11
   } pin_role_e;

   // Overtemperature timer states.
   typedef enum logic {
      OT_IDLE   = 1'b0,
      OT_TIMING = 1'b1
   } timer_state_e;

   typedef logic [7:0] reg_byte_t;

endpackage : fan_sense_pkg

// ---- logic/fan_sense_regs.svh ----
// Register offsets, field positions, reset values and timing figures
// for the fan sense configuration and overtemperature timer block.
// Assumes a serial management bus slave delivers byte-wide accesses.
`ifndef FAN_SENSE_REGS_SVH
`define FAN_SENSE_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CFG_OFFSET        8'h78
`define OT_STATUS_OFFSET  8'h79
`define OT_LIMIT_OFFSET   8'h7A
`define PPR_OFFSET        8'h7B

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFG_RESET         8'h00
`define OT_STATUS_RESET   8'h00
`define OT_LIMIT_RESET    8'h00
`define PPR_RESET         8'h55

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CFG_ALERT_EN      0
`define CFG_TIMER_EN      1
`define CFG_BOOST         2
`define CFG_FAST          3
`define CFG_CONT_LSB      4
`define MASK_TIMER_EVENT  5

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define CLK_MHZ           50
`define OT_STEP_US        22760
`define OT_REPORT_STEPS   2
`define FAST_PERIOD_MS    250
`define SLOW_PERIOD_MS    1000

`endif

// ---- logic/overtemp_timer.sv ----
// Overtemperature assertion timer: flag, duration count, limit event.
// Assumes the active level is already gated by enable and pin role.
`timescale 1ns/1ps
`include "fan_sense_regs.svh"
module overtemp_timer
   import fan_sense_pkg::*;
#(
   parameter int STEP_CYCLES = 1138000
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_b,
   // Register block side
   overtemp_timer_if.timer tif
);
   localparam int PW = $clog2(STEP_CYCLES + 1);

   initial begin
      if (STEP_CYCLES < 1)
         $error("overtemp_timer: step must be at least one cycle");
   end

   timer_state_e  state;
   timer_state_e  next_state;
   logic [PW-1:0] presc;
   logic [PW-1:0] next_presc;
   reg_byte_t     count;
   reg_byte_t     next_count;
   reg_byte_t     status;
   reg_byte_t     next_status;
   logic          fired;
   logic          next_fired;
   logic          next_event;
   logic          event_q;

   // Reads clear the status first, so any hardware update below wins.
   always_comb begin
      next_state  = state;
      next_presc  = presc;
      next_count  = count;
      next_fired  = fired;
      next_event  = 1'b0;
      next_status = tif.rd_clear ? `OT_STATUS_RESET : status;
      unique case (state)
         OT_IDLE: begin
            if (tif.active) begin
               next_state  = OT_TIMING;
               next_presc  = '0;
               next_count  = 8'h00;
               next_status = 8'h01;
               next_fired  = 1'b0;
               if (tif.limit == 8'h00) begin
                  next_event = 1'b1;
                  next_fired = 1'b1;
               end
            end
         end
         OT_TIMING: begin
            if (!tif.active) begin
               next_state = OT_IDLE;
            end else begin
               if (presc == PW'(STEP_CYCLES - 1)) begin
                  next_presc = '0;
                  if (count != 8'hFF)
                     next_count = count + 8'h01;
               end else begin
                  next_presc = presc + 1'b1;
               end
               if (count >= `OT_REPORT_STEPS)
                  next_status = count;
               if (!fired && tif.limit != 8'h00 && count > tif.limit) begin
                  next_event = 1'b1;
                  next_fired = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state   <= OT_IDLE;
         presc   <= '0;
         count   <= 8'h00;
         status  <= `OT_STATUS_RESET;
         fired   <= 1'b0;
         event_q <= 1'b0;
      end else begin
         state   <= next_state;
         presc   <= next_presc;
         count   <= next_count;
         status  <= next_status;
         fired   <= next_fired;
         event_q <= next_event;
      end
   end

   assign tif.status      = status;
   assign tif.limit_event = event_q;
   assign tif.timing      = (state == OT_TIMING);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_assert_start;
      state == OT_IDLE && tif.active;
   endsequence

   a_flag_on_assert: assert property (
      s_assert_start |=> status == 8'h01)
      else $error("assert flag not set on new assertion");
   a_read_clears: assert property (
      (tif.rd_clear && !tif.active && state == OT_IDLE)
      |=> status == 8'h00)
      else $error("status not cleared by read");
   a_upper_zero: assert property (
      (state == OT_TIMING && count < `OT_REPORT_STEPS)
      |-> status[7:1] == 7'h00)
      else $error("upper timer bits set too early");
   a_count_report: assert property (
      (state == OT_TIMING && tif.active && count >= `OT_REPORT_STEPS)
      |=> status == $past(count))
      else $error("status does not follow duration count");
   a_count_saturate: assert property (count == 8'hFF |=> count != 8'h00)
      else $error("duration count wrapped");
   a_zero_limit_evt: assert property (
      (s_assert_start ##0 tif.limit == 8'h00) |=> tif.limit_event)
      else $error("zero limit did not raise event at once");

endmodule : overtemp_timer

// ---- logic/overtemp_timer_and_fan_sense_config.sv ----
// Fan sense configuration, overtemperature assertion timer and
// pulses-per-revolution registers, with the shared pin steering.
// Assumes a serial bus slave in front turns bus transfers into single
// cycle read and write strobes with a byte address, and that the lock
// bit, pin role field and interrupt mask bit come from registers kept
// elsewhere in the device.
//
// How it works
// - alert enable bit makes fan drive pin B the bus alert output.
// - config bit 1 enables the timer when the shared pin is overtemp.
// - overtemp input plus boost forces all fans to maximum duty.
// - fast bit samples all fan speeds every 250 ms, else every second.
// - bits 4 to 7 give continuous measurement, no stretching, per fan.
// - after global lock, writes to the configuration byte are ignored.
// - status bit 0 sets on input assertion and clears on read.
// - beyond 45.52 ms status holds the 22.76 ms step count.
// - status bits 7 to 1 read zero until 45.52 ms have passed.
// - duration above the limit raises the timer interrupt status bit.
// - a zero limit raises the interrupt at once on assertion.
// - two-bit field per fan selects one to four counted pulses.
// - shared pin role: speed input, overtemp, bus alert, or GPIO.
// - when the shared pin is overtemp, mask bit 5 blocks timer alerts.
`timescale 1ns/1ps
`include "fan_sense_regs.svh"
module overtemp_timer_and_fan_sense_config
   import fan_sense_pkg::*;
#(
   parameter int STEP_CYCLES = `OT_STEP_US * `CLK_MHZ,
   parameter int FAST_CYCLES = `FAST_PERIOD_MS * 1000 * `CLK_MHZ,
   parameter int SLOW_CYCLES = `SLOW_PERIOD_MS * 1000 * `CLK_MHZ
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Register access from the serial bus slave
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   output logic            reg_hit,
   // Settings held elsewhere in the device
   input  wire logic       config_lock,
   input  wire logic [1:0] shared_pin_role_select,
   input  wire logic       fourth_fan_or_timer_event_mask,
   // Overtemperature input, active low
   input  wire logic       overtemp_signal_b,
   // Fan drive pin B and bus alert sharing
   input  wire logic       fan_drive_output_b,
   input  wire logic       alert_request,
   output logic            drive_b_pin_out,
   output logic            drive_b_pin_oe,
   // Shared multi-function pin role
   output logic            fan_speed_input_d_sel,
   output logic            overtemp_pin_sel,
   output logic            bus_alert_pin_sel,
   output logic            gpio_pin_sel,
   // Fan control and speed measurement
   output logic            force_max_duty,
   output logic            speed_sample_tick,
   output logic            continuous_speed_meas_a,
   output logic            continuous_speed_meas_b,
   output logic            continuous_speed_meas_c,
   output logic            continuous_speed_meas_d,
   output logic [3:0]      pulse_stretch_off,
   output logic [2:0]      pulse_count_select_a,
   output logic [2:0]      pulse_count_select_b,
   output logic [2:0]      pulse_count_select_c,
   output logic [2:0]      pulse_count_select_d,
   // Timer limit event toward interrupt status
   output logic            fourth_fan_or_timer_event,
   output logic            timer_alert_event
);

   initial begin
      if (STEP_CYCLES < 1 || FAST_CYCLES < 2 || SLOW_CYCLES < FAST_CYCLES)
         $error("fan sense config: timing parameters out of range");
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Pulses counted per measurement: field value plus one.
   function automatic logic [2:0] pulses_counted(input logic [1:0] fld);
      pulses_counted = {1'b0, fld} + 3'h1;
   endfunction : pulses_counted

   // True when a strobe addresses the given register.
   function automatic logic hits(input logic [7:0] addr,
                                 input logic [7:0] offset);
      hits = (addr == offset);
   endfunction : hits

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg_byte_t cfg;
   reg_byte_t next_cfg;
   reg_byte_t limit;
   reg_byte_t next_limit;
   reg_byte_t ppr;
   reg_byte_t next_ppr;
   reg_byte_t rdata;
   reg_byte_t next_rdata;
   logic      hit;
   logic      next_hit;
   logic      overtemp_active;
   logic      timer_enable;
   pin_role_e role;

   overtemp_timer_if tif ();

   assign role = pin_role_e'(shared_pin_role_select);

   // Writes. The lock makes only the configuration byte read-only here;
   // the limit and pulse fields are not covered by it.
   always_comb begin
      next_cfg   = cfg;
      next_limit = limit;
      next_ppr   = ppr;
      if (reg_wr) begin
         if (hits(reg_addr, `CFG_OFFSET) && !config_lock)
            next_cfg = reg_wdata;
         if (hits(reg_addr, `OT_LIMIT_OFFSET))
            next_limit = reg_wdata;
         if (hits(reg_addr, `PPR_OFFSET))
            next_ppr = reg_wdata;
      end
   end

   // Read data is captured on the strobe edge; unmapped reads give zero.
   always_comb begin
      next_rdata = rdata;
      next_hit   = hit;
      if (reg_rd) begin
         next_hit = 1'b1;
         if (hits(reg_addr, `CFG_OFFSET))
            next_rdata = cfg;
         else if (hits(reg_addr, `OT_STATUS_OFFSET))
            next_rdata = tif.status;
         else if (hits(reg_addr, `OT_LIMIT_OFFSET))
            next_rdata = limit;
         else if (hits(reg_addr, `PPR_OFFSET))
            next_rdata = ppr;
         else begin
            next_rdata = 8'h00;
            next_hit   = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cfg   <= `CFG_RESET;
         limit <= `OT_LIMIT_RESET;
         ppr   <= `PPR_RESET;
         rdata <= 8'h00;
         hit   <= 1'b0;
      end else begin
         cfg   <= next_cfg;
         limit <= next_limit;
         ppr   <= next_ppr;
         rdata <= next_rdata;
         hit   <= next_hit;
      end
   end

   assign reg_rdata = rdata;
   assign reg_hit   = hit;

   // ----------------------------------------------------------------
   // Shared pin role and fan drive pin B
   // ----------------------------------------------------------------

   // Pin role decode from the two-bit select.
   always_comb begin
      fan_speed_input_d_sel = (role == ROLE_FAN_SPEED);
      overtemp_pin_sel      = (role == ROLE_OVERTEMP);
      bus_alert_pin_sel     = (role == ROLE_BUS_ALERT);
      gpio_pin_sel          = (role == ROLE_GPIO);
   end

   // As bus alert the pin is open drain: it only ever pulls low.
   always_comb begin
      if (cfg[`CFG_ALERT_EN]) begin
         drive_b_pin_out = 1'b0;
         drive_b_pin_oe  = alert_request;
      end else begin
         drive_b_pin_out = fan_drive_output_b;
         drive_b_pin_oe  = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Overtemperature input, boost and timer
   // ----------------------------------------------------------------

   // Timing and boost only listen when the shared pin is the overtemp input.
   assign overtemp_active = overtemp_pin_sel && !overtemp_signal_b;
   assign timer_enable    = cfg[`CFG_TIMER_EN] && overtemp_pin_sel;
   assign force_max_duty  = overtemp_active && cfg[`CFG_BOOST];

   assign tif.active   = overtemp_active && timer_enable;
   assign tif.limit    = limit;
   assign tif.rd_clear = reg_rd && hits(reg_addr, `OT_STATUS_OFFSET);

   overtemp_timer #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_timer (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .tif     (tif.timer)
   );

   // The raw event always reaches interrupt status; the mask gates alert.
   assign fourth_fan_or_timer_event = tif.limit_event;
   assign timer_alert_event = tif.limit_event && overtemp_pin_sel
                              && !fourth_fan_or_timer_event_mask;

   // ----------------------------------------------------------------
   // Speed measurement settings
   // ----------------------------------------------------------------
   sample_tick_gen #(
      .FAST_CYCLES (FAST_CYCLES),
      .SLOW_CYCLES (SLOW_CYCLES)
   ) u_tick (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .fast    (cfg[`CFG_FAST]),
      .tick    (speed_sample_tick)
   );

   // Continuous measurement also turns stretching off on that channel.
   // Only dc powered fans may use it; this logic cannot tell.
   always_comb begin
      continuous_speed_meas_a = cfg[`CFG_CONT_LSB];
      continuous_speed_meas_b = cfg[`CFG_CONT_LSB + 1];
      continuous_speed_meas_c = cfg[`CFG_CONT_LSB + 2];
      continuous_speed_meas_d = cfg[`CFG_CONT_LSB + 3];
      pulse_stretch_off       = cfg[7:`CFG_CONT_LSB];
   end

   // Pulses counted per measurement for each fan.
   always_comb begin
      pulse_count_select_a = pulses_counted(ppr[1:0]);
      pulse_count_select_b = pulses_counted(ppr[3:2]);
      pulse_count_select_c = pulses_counted(ppr[5:4]);
      pulse_count_select_d = pulses_counted(ppr[7:6]);
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_lock_blocks_wr: assert property (
      (reg_wr && config_lock && hits(reg_addr, `CFG_OFFSET))
      |=> cfg == $past(cfg))
      else $error("locked configuration was written");
   a_cfg_write_ok: assert property (
      (reg_wr && !config_lock && hits(reg_addr, `CFG_OFFSET))
      |=> cfg == $past(reg_wdata))
      else $error("unlocked configuration write lost");
   a_alert_pin_mux: assert property (
      cfg[`CFG_ALERT_EN] |-> (!drive_b_pin_out
                              && drive_b_pin_oe == alert_request))
      else $error("drive pin B not acting as bus alert");
   a_boost_forces: assert property (
      (overtemp_pin_sel && !overtemp_signal_b && cfg[`CFG_BOOST])
      |-> force_max_duty)
      else $error("boost did not force maximum duty");
   a_timer_gate: assert property (
      (!overtemp_pin_sel || !cfg[`CFG_TIMER_EN]) [*2] |-> !tif.timing)
      else $error("timer ran while disabled");
   a_cont_meas_map: assert property (
      $rose(cfg[`CFG_CONT_LSB + 3]) |-> continuous_speed_meas_d
                                        && pulse_stretch_off[3])
      else $error("continuous measurement bit not applied");
   a_ppr_decode: assert property (
      (reg_wr && hits(reg_addr, `PPR_OFFSET)
       && reg_wdata[3:2] == 2'b11) |=> pulse_count_select_b == 3'h4)
      else $error("pulse count select decoded wrong");
   a_limit_mask: assert property (
      (tif.limit_event && fourth_fan_or_timer_event_mask)
      |-> !timer_alert_event && fourth_fan_or_timer_event)
      else $error("masked timer event reached alert");
   a_role_decode: assert property (
      $onehot({fan_speed_input_d_sel, overtemp_pin_sel,
               bus_alert_pin_sel, gpio_pin_sel}))
      else $error("pin role decode not one-hot");

endmodule : overtemp_timer_and_fan_sense_config

// ---- logic/overtemp_timer_if.sv ----
// Carrier between the register block and the overtemperature timer.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface overtemp_timer_if;
   import fan_sense_pkg::*;
   logic      active;
   logic      rd_clear;
   reg_byte_t limit;
   reg_byte_t status;
   logic      limit_event;
   logic      timing;

   modport ctrl  (output active, rd_clear, limit,
                  input  status, limit_event, timing);
   modport timer (input  active, rd_clear, limit,
                  output status, limit_event, timing);
endinterface : overtemp_timer_if

// ---- logic/sample_tick_gen.sv ----
// Speed measurement period generator: one tick per sampling period.
// Assumes the fast select is a registered configuration bit.
`timescale 1ns/1ps
module sample_tick_gen #(
   parameter int FAST_CYCLES = 12500000,
   parameter int SLOW_CYCLES = 50000000
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_b,
   // Control and result
   input  wire logic fast,
   output logic      tick
);
   localparam int CW = $clog2(SLOW_CYCLES + 1);

   initial begin
      if (FAST_CYCLES < 2 || SLOW_CYCLES < FAST_CYCLES)
         $error("sample_tick_gen: bad period parameters");
   end

   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic [CW-1:0] last;

   // A mode change takes effect at once; a count past the new end wraps.
   always_comb begin
      last = fast ? CW'(FAST_CYCLES - 1) : CW'(SLOW_CYCLES - 1);
      next_cnt = (cnt >= last) ? '0 : cnt + 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end

   assign tick = (cnt >= last);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [CW-1:0] gap;
   logic          steady;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         gap    <= '0;
         steady <= 1'b1;
      end else begin
         gap    <= tick ? '0 : gap + 1'b1;
         steady <= tick ? 1'b1 : (steady && fast == $past(fast));
      end
   end

   a_fast_period_len: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (tick && fast && steady && $past(fast)) |-> gap == CW'(FAST_CYCLES - 1))
      else $error("fast sampling period wrong");

endmodule : sample_tick_gen

// ---- verification/fan_host_model.sv ----
// Far side model: fan drive source, overtemperature pin, host policy.
// Assumes the bench requests overtemperature through ot_req.
`timescale 1ns/1ps
module fan_host_model #(
   parameter logic [3:0] DC_FANS = 4'hA
) (
   // Clock
   input  wire logic  sys_clk,
   // Request from the bench
   input  wire logic  ot_req,
   // Far side pins and host policy
   output logic       overtemp_signal_b,
   output logic       fan_drive_output_b,
   output logic [3:0] dc_fans
);
   logic [1:0] phase = 2'h0;

   // Only fans on a dc supply may be given continuous measurement.
   assign dc_fans = DC_FANS;
   // The pin has a pull-up, so it idles high when nobody asserts it.
   assign overtemp_signal_b = ~ot_req;
   // Crude pulsed drive that toggles every second cycle.
   always_ff @(posedge sys_clk) begin
      phase <= phase + 2'h1;
   end
   assign fan_drive_output_b = phase[1];
endmodule : fan_host_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the fan sense and overtemperature block.
// Assumes short counts: step 4, fast 8 and slow 32 cycles.
`timescale 1ns/1ps
`include "fan_sense_regs.svh"
module tb_top;
   import fan_sense_pkg::*;
   logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
   logic config_lock = 0, alert_request = 0, ot_req = 0;
   logic fourth_fan_or_timer_event_mask = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [1:0] shared_pin_role_select = 0;
   logic reg_hit, overtemp_signal_b, fan_drive_output_b, drive_b_pin_out;
   logic drive_b_pin_oe, fan_speed_input_d_sel, overtemp_pin_sel;
   logic bus_alert_pin_sel, gpio_pin_sel, force_max_duty, speed_sample_tick;
   logic continuous_speed_meas_a, continuous_speed_meas_b;
   logic continuous_speed_meas_c, continuous_speed_meas_d;
   logic fourth_fan_or_timer_event, timer_alert_event;
   logic [3:0] pulse_stretch_off, dc_fans;
   logic [2:0] pulse_count_select_a, pulse_count_select_b;
   logic [2:0] pulse_count_select_c, pulse_count_select_d;
   int n_mismatch = 0, cmp_count = 0;

   overtemp_timer_and_fan_sense_config #(.STEP_CYCLES(4), .FAST_CYCLES(8),
      .SLOW_CYCLES(32)) dut_u (.*);
   fan_host_model far_u (.sys_clk(sys_clk), .ot_req(ot_req),
      .overtemp_signal_b(overtemp_signal_b),
      .fan_drive_output_b(fan_drive_output_b), .dc_fans(dc_fans));

   // Free running clock, 20 ns period.
   always #10 sys_clk = ~sys_clk;

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data lands at the edge that samples the strobe.
   task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(what, exp, reg_rdata);
   endtask : rd

   task automatic t_reset();
      rd(`CFG_OFFSET, 8'h00, "cfg");
      rd(`OT_LIMIT_OFFSET, 8'h00, "limit");
      rd(`PPR_OFFSET, 8'h55, "ppr");
      chk("hit", 1, reg_hit);
      rd(8'h80, 8'h00, "unmapped");
      chk("miss", 0, reg_hit);
      chk("pin", {fan_drive_output_b, 1'b1},
         {drive_b_pin_out, drive_b_pin_oe});
      for (int r = 0; r < 4; r++) begin
         shared_pin_role_select <= 2'(r);
         @(posedge sys_clk);
         #1 chk("role", 4'h1 << r, {gpio_pin_sel, bus_alert_pin_sel,
            overtemp_pin_sel, fan_speed_input_d_sel});
      end
   endtask : t_reset

   task automatic t_ppr();
      for (int c = 0; c < 4; c++) begin
         wr(`PPR_OFFSET, {4{2'(c)}});
         #1 chk("counts", {4{3'(c + 1)}}, {pulse_count_select_a,
            pulse_count_select_b, pulse_count_select_c,
            pulse_count_select_d});
      end
   endtask : t_ppr

   task automatic t_cfg();
      wr(`CFG_OFFSET, {dc_fans, 4'h1});
      #1 chk("cont", {dc_fans, dc_fans}, {continuous_speed_meas_d,
         continuous_speed_meas_c, continuous_speed_meas_b,
         continuous_speed_meas_a, pulse_stretch_off});
      @(posedge sys_clk);
      alert_request <= 1'b1;
      #1 chk("alert on", 2'b01, {drive_b_pin_out, drive_b_pin_oe});
      @(posedge sys_clk);
      alert_request <= 1'b0;
      #1 chk("alert off", 0, drive_b_pin_oe);
      @(posedge sys_clk);
      config_lock <= 1'b1;
      wr(`CFG_OFFSET, 8'h00);
      rd(`CFG_OFFSET, {dc_fans, 4'h1}, "locked");
      config_lock <= 1'b0;
   endtask : t_cfg

   // Measures the gap between two ticks once the new rate has settled.
   task automatic t_tick(logic [7:0] cfg, int per);
      int n;
      wr(`CFG_OFFSET, cfg);
      repeat (2) @(posedge speed_sample_tick);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (speed_sample_tick !== 1'b1 && n < 100);
      chk("period", per, n);
   endtask : t_tick

   // Status is read once the input has gone, so no update races the read.
   task automatic t_ot(logic [7:0] lim, int hold, logic [7:0] st, logic msk);
      int n;
      shared_pin_role_select <= ROLE_OVERTEMP;
      fourth_fan_or_timer_event_mask <= msk;
      wr(`OT_LIMIT_OFFSET, lim);
      wr(`CFG_OFFSET, 8'h06);
      ot_req <= 1'b1;
      n = 0;
      while (fourth_fan_or_timer_event !== 1'b1 && n < 24) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk("event", {1'b1, ~msk}, {fourth_fan_or_timer_event,
         timer_alert_event});
      chk("boost", 1, force_max_duty);
      repeat (hold) @(posedge sys_clk);
      ot_req <= 1'b0;
      rd(`OT_STATUS_OFFSET, st, "status");
      rd(`OT_STATUS_OFFSET, 8'h00, "cleared");
   endtask : t_ot

   task automatic tally_and_finish();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence, reset held for six cycles.
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_ppr();
      t_cfg();
      t_tick(8'h08, 8);
      t_tick(8'h00, 32);
      t_ot(8'h00, 1, 8'h01, 1'b1);
      t_ot(8'h01, 1100, 8'hFF, 1'b0);
      tally_and_finish();
   end

   // Whole run needs about 1300 cycles, so 5000 means a hang.
   initial begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : tb_top
